// >>> rtl/uscr_consts.vh
// Constants for the suspend and reset pin controller.
// Included by the controller module only.
`ifndef USCR_CONSTS_VH
`define USCR_CONSTS_VH
`define USCR_ST_RUN       2'h0
`define USCR_ST_SUSPEND   2'h1
`define USCR_ST_PWRDOWN   2'h2
`define USCR_EP_COUNT     2'h3
`define USCR_EP_DESC      2'h0
`define USCR_EP_REGS      2'h1
`define USCR_EP_VIDEO     2'h2
`define USCR_ALT_MAX      4'hf
`define USCR_KBPS_STEP    14'h01f4
`define USCR_KBPS_MAX     14'h1f40
`define USCR_REG_PKT_MAX  4'h8
`define USCR_REG_KBPS_MAX 9'h100
`define USCR_DEF_CONFIG   8'h01
`define USCR_XTAL_MHZ     6'h30
`define USCR_RST_SYNC     2'h3
`define USCR_RST_DONE     2'h0
`define USCR_RST_STEP     2'h1
`endif

// >>> rtl/uscr_ctrl.v
// Suspend, power-down and reset pin control for a USB video bridge.
// Assumes a USB core reports bus reset, suspend, resume and the chosen alternate setting.
// How it works
// - Without EEPROM, power code msb comes from its pin; otherwise ignored.
// - With EEPROM, drive eeprom clock; without, read it as power lsb.
// - Eeprom clock pin is held high during suspend.
// - Eeprom data pin sampled at reset decides EEPROM presence; floats in suspend.
// - Serial control enable is forced low in suspend or power-down.
// - Camera data pin is open-drain and released in suspend or power-down.
// - Camera clock is driven low in suspend or power-down.
// - Camera power-off released at reset and suspend, stays so until software.
// - Both USB line drivers are released throughout suspend.
// - Power-on reset and USB bus reset merge into one driven reset output.
// - Three endpoints: descriptors, register bank, and video.
// - Video endpoint uses half to eight megabits per second.
// - No EEPROM gives default descriptors with configuration one only.
// - Host picks video rate by alternate setting, eight down by halves.
// - All clocks come from one crystal; unused clocks are gated off.
// - Register channel packets are at most eight bytes, up to 256 kbps.
// - Video travels over an isochronous pipe at eight megabits at most.
// - Suspend indicator low on reset, floats in suspend, low after resume.
`timescale 1ns/1ns
`default_nettype none
`include "uscr_consts.vh"
module uscr_ctrl (
   input  wire        mclk_in,                        // System clock.
   input  wire        arst_n_in,                      // Power-on reset, active low.
   input  wire        usb_bus_reset_in,               // Bus reset seen by the USB core.
   input  wire        usb_suspend_in,                 // USB core requests suspend.
   input  wire        usb_resume_in,                  // USB core saw resume.
   input  wire        power_down_in,                  // Software power-down request.
   input  wire [3:0]  alt_setting_in,                 // Selected alternate setting.
   input  wire        power_code_msb_pin_in,          // Static power code msb level.
   input  wire        eeprom_clock_or_power_lsb_pin_in,  // Shared pin level.
   input  wire        eeprom_clk_core_in,             // Clock from EEPROM engine.
   input  wire        eeprom_data_pin_in,             // EEPROM data / detect level.
   input  wire        eeprom_data_drive_low_in,       // EEPROM engine pulls data low.
   input  wire        serial_control_enable_core_in,  // Enable from serial engine.
   input  wire        camera_ctrl_data_low_in,        // Serial engine pulls data low.
   input  wire        camera_ctrl_clock_core_in,      // Clock from serial engine.
   input  wire        camera_power_on_wr_in,          // Software write strobe.
   input  wire        camera_power_on_val_in,         // Written value, 1 = camera on.
   input  wire        usb_plus_core_in,               // Transmit level, plus line.
   input  wire        usb_minus_core_in,              // Transmit level, minus line.
   input  wire        usb_drive_core_in,              // Transmit enable from core.
   input  wire [3:0]  reg_pkt_len_in,                 // Requested register packet length.
   output reg         combined_reset_n_out,           // Merged reset, active low.
   output reg         eeprom_present_out,             // EEPROM detected at reset.
   output reg  [1:0]  device_power_code_out,          // Descriptor power code.
   output reg         use_default_desc_out,           // Built-in descriptors in use.
   output wire [7:0]  default_config_out,             // Only default configuration.
   output wire [1:0]  endpoint_count_out,             // Number of endpoints.
   output reg  [13:0] video_kbps_out,                 // Video bandwidth in kbit/s.
   output wire        video_iso_out,                  // Video endpoint is isochronous.
   output wire [3:0]  reg_pkt_len_out,                // Clamped register packet length.
   output reg         suspended_out,                  // Suspend state flag.
   output reg         video_clk_en_out,               // Gate for unused clocks.
   output wire        eeprom_clock_or_power_lsb_pin_out,  // Shared pin level.
   output wire        eeprom_clock_or_power_lsb_pin_oe_out,  // Shared pin enable.
   output wire        eeprom_data_pin_out,            // Always low when enabled.
   output wire        eeprom_data_pin_oe_out,         // Open-drain enable.
   output wire        serial_control_enable_out,      // Serial control enable.
   output wire        camera_ctrl_data_pin_out,       // Always low when enabled.
   output wire        camera_ctrl_data_pin_oe_out,    // Open-drain enable.
   output wire        camera_ctrl_clock_pin_out,      // Camera control clock.
   output wire        camera_power_off_pin_out,       // Always low when enabled.
   output wire        camera_power_off_pin_oe_out,    // Enable, high = camera on.
   output wire        suspend_indicator_pin_out,      // Always low when enabled.
   output wire        suspend_indicator_pin_oe_out,   // Enable, released in suspend.
   output wire        bus_plus_line_out,              // Plus line level.
   output wire        bus_plus_line_oe_out,           // Plus line enable.
   output wire        bus_minus_line_out,             // Minus line level.
   output wire        bus_minus_line_oe_out           // Minus line enable.
);

   reg  [1:0]  state_reg;
   reg  [1:0]  state_next;
   reg  [1:0]  rst_cnt_reg;
   reg  [3:0]  pkt_len_reg;
   reg         cam_on_reg;
   reg         in_reset_reg;
   reg         ee_clk_lvl;
   reg         ee_clk_oe;
   reg         ee_data_oe;
   reg         serial_control_enable_out_lvl;
   reg         cam_data_oe;
   reg         cam_clk_lvl;
   reg         cam_pwr_oe;
   reg         susp_ind_oe;
   reg         usb_oe;
   wire        quiet;
   wire        susp;
   wire        pwrdn;
   wire        strap_take;
   wire        strap_hold;

   // Rate step by step: setting zero is the full rate, each step takes half a megabit off.
   function [13:0] alt_to_kbps;
      input [3:0] alt;
      begin
         alt_to_kbps = `USCR_KBPS_MAX - (`USCR_KBPS_STEP * {10'h000, alt});
      end
   endfunction

   // Longer register packets are cut to the largest one the channel carries.
   function [3:0] clamp_pkt;
      input [3:0] len;
      begin
         if (len > `USCR_REG_PKT_MAX) begin
            clamp_pkt = `USCR_REG_PKT_MAX;
         end else begin
            clamp_pkt = len;
         end
      end
   endfunction

   // The two straps pair as msb then lsb, the order of the descriptor field.
   function [1:0] power_code_of;
      input msb;
      input lsb;
      begin
         power_code_of = {msb, lsb};
      end
   endfunction

   // The bus reset is only seen synchronously; holding the merged reset a few
   // cycles gives external circuits a clean pulse even for a short bus reset.
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_cnt_reg          <= `USCR_RST_SYNC;
         combined_reset_n_out <= 1'b0;
      end else if (usb_bus_reset_in) begin
         rst_cnt_reg          <= `USCR_RST_SYNC;
         combined_reset_n_out <= 1'b0;
      end else if (rst_cnt_reg != `USCR_RST_DONE) begin
         rst_cnt_reg          <= rst_cnt_reg - `USCR_RST_STEP;
         combined_reset_n_out <= 1'b0;
      end else begin
         combined_reset_n_out <= 1'b1;
      end
   end

   // Straps are caught on the first clock after the merged reset ends, never in
   // the asynchronous branch.
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         in_reset_reg          <= 1'b1;
         eeprom_present_out    <= 1'b0;
         device_power_code_out <= 2'h0;
         use_default_desc_out  <= 1'b1;
      end else begin
         in_reset_reg <= ~combined_reset_n_out;
         if (strap_take) begin
            eeprom_present_out   <= eeprom_data_pin_in;
            use_default_desc_out <= ~eeprom_data_pin_in;
            if (!eeprom_data_pin_in) begin
               // With an EEPROM fitted both straps are ignored and the code stays put.
               device_power_code_out <= power_code_of(power_code_msb_pin_in,
                                                      eeprom_clock_or_power_lsb_pin_in);
            end
         end
      end
   end

   // Suspend outranks power-down from every state, and a resume lands in
   // power-down while software still asks for it, so serial enable and the camera control pins do not wake for a cycle.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `USCR_ST_RUN: begin
            if (usb_suspend_in) begin
               state_next = `USCR_ST_SUSPEND;
            end else if (power_down_in) begin
               state_next = `USCR_ST_PWRDOWN;
            end
         end
         `USCR_ST_SUSPEND: begin
            if (usb_resume_in && power_down_in) begin
               state_next = `USCR_ST_PWRDOWN;
            end else if (usb_resume_in) begin
               state_next = `USCR_ST_RUN;
            end
         end
         `USCR_ST_PWRDOWN: begin
            if (usb_suspend_in) begin
               state_next = `USCR_ST_SUSPEND;
            end else if (!power_down_in) begin
               state_next = `USCR_ST_RUN;
            end
         end
         default: begin
            state_next = `USCR_ST_RUN;
         end
      endcase
   end

   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_reg        <= `USCR_ST_RUN;
         cam_on_reg       <= 1'b0;
         suspended_out    <= 1'b0;
         video_clk_en_out <= 1'b0;
         video_kbps_out   <= `USCR_KBPS_MAX;
      end else if (!combined_reset_n_out) begin
         state_reg        <= `USCR_ST_RUN;
         cam_on_reg       <= 1'b0;
         suspended_out    <= 1'b0;
         video_clk_en_out <= 1'b0;
         video_kbps_out   <= `USCR_KBPS_MAX;
      end else begin
         state_reg     <= state_next;
         suspended_out <= (state_next == `USCR_ST_SUSPEND);
         video_clk_en_out <= (state_next == `USCR_ST_RUN);
         // A write in the entry cycle loses, so suspend always leaves the camera off.
         if (state_next == `USCR_ST_SUSPEND && state_reg != `USCR_ST_SUSPEND) begin
            cam_on_reg <= 1'b0;
         end else if (camera_power_on_wr_in) begin
            cam_on_reg <= camera_power_on_val_in;
         end
         // The host sees its chosen rate one cycle after the setting changes.
         video_kbps_out <= alt_to_kbps(alt_setting_in);
      end
   end

   // The packet length is stored already cut, so the data output is a flip-flop.
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pkt_len_reg <= `USCR_REG_PKT_MAX;
      end else begin
         pkt_len_reg <= clamp_pkt(reg_pkt_len_in);
      end
   end

   // Power-down only matters for pins that also list it; suspend covers all.
   assign susp  = (state_reg == `USCR_ST_SUSPEND);
   assign pwrdn = (state_reg == `USCR_ST_PWRDOWN);
   assign quiet = susp | pwrdn;

   // The detect level is taken one clock after the merged reset ends; the data
   // driver stays off until then, or a pull from the engine would hide the EEPROM.
   assign strap_take = in_reset_reg & combined_reset_n_out;
   assign strap_hold = in_reset_reg | ~combined_reset_n_out;

   // Every override except the strap_hold one keys on the registered state alone, so all forced pins move
   // on the same edge; the cost is one cycle of latency after each request.
   always @* begin
      ee_clk_lvl  = eeprom_clk_core_in;
      ee_clk_oe   = eeprom_present_out;
      ee_data_oe  = eeprom_present_out & eeprom_data_drive_low_in;
      serial_control_enable_out_lvl    = serial_control_enable_core_in;
      cam_data_oe = camera_ctrl_data_low_in;
      cam_clk_lvl = camera_ctrl_clock_core_in;
      cam_pwr_oe  = cam_on_reg;
      susp_ind_oe = 1'b1;
      usb_oe      = usb_drive_core_in;
      if (strap_hold) begin
         ee_data_oe = 1'b0;
      end
      if (quiet) begin
         serial_control_enable_out_lvl    = 1'b0;
         cam_data_oe = 1'b0;
         cam_clk_lvl = 1'b0;
      end
      if (susp) begin
         ee_clk_lvl  = 1'b1;
         ee_clk_oe   = 1'b1;
         ee_data_oe  = 1'b0;
         cam_pwr_oe  = 1'b0;
         susp_ind_oe = 1'b0;
         usb_oe      = 1'b0;
      end
   end

   assign eeprom_clock_or_power_lsb_pin_out    = ee_clk_lvl;
   assign eeprom_clock_or_power_lsb_pin_oe_out = ee_clk_oe;
   assign eeprom_data_pin_out           = 1'b0;
   assign eeprom_data_pin_oe_out        = ee_data_oe;
   assign serial_control_enable_out     = serial_control_enable_out_lvl;
   assign camera_ctrl_data_pin_out      = 1'b0;
   assign camera_ctrl_data_pin_oe_out   = cam_data_oe;
   assign camera_ctrl_clock_pin_out     = cam_clk_lvl;
   assign camera_power_off_pin_out      = 1'b0;
   assign camera_power_off_pin_oe_out   = cam_pwr_oe;
   assign suspend_indicator_pin_out     = 1'b0;
   assign suspend_indicator_pin_oe_out  = susp_ind_oe;
   assign bus_plus_line_out             = usb_plus_core_in;
   assign bus_plus_line_oe_out          = usb_oe;
   assign bus_minus_line_out            = usb_minus_core_in;
   assign bus_minus_line_oe_out         = usb_oe;

   assign default_config_out = `USCR_DEF_CONFIG;
   assign endpoint_count_out = `USCR_EP_COUNT;
   assign video_iso_out      = 1'b1;
   assign reg_pkt_len_out    = pkt_len_reg;

endmodule
`default_nettype wire

// >>> test/usb_camera_suspend_reset_ctrl_test.sv
// Self-checking bench for the suspend and reset pin controller.
// Assumes the board model resolves the straps; all core-side levels move together.
`timescale 1ns/1ns
`default_nettype none
module usb_camera_suspend_reset_ctrl_test;
   logic mclk_in, arst_n_in, usb_bus_reset_in, usb_suspend_in, usb_resume_in, power_down_in;
   logic power_code_msb_pin_in, eeprom_clock_or_power_lsb_pin_in, eeprom_data_pin_in, core_on;
   logic eeprom_clk_core_in, eeprom_data_drive_low_in, serial_control_enable_core_in;
   logic camera_ctrl_data_low_in, camera_ctrl_clock_core_in, usb_plus_core_in, usb_minus_core_in;
   logic usb_drive_core_in, camera_power_on_wr_in, camera_power_on_val_in, bus_minus_line_oe_out;
   logic combined_reset_n_out, eeprom_present_out, use_default_desc_out, video_iso_out;
   logic suspended_out, video_clk_en_out, eeprom_clock_or_power_lsb_pin_out, eeprom_data_pin_out;
   logic eeprom_clock_or_power_lsb_pin_oe_out, eeprom_data_pin_oe_out, serial_control_enable_out;
   logic camera_ctrl_data_pin_out, camera_ctrl_data_pin_oe_out, camera_ctrl_clock_pin_out;
   logic camera_power_off_pin_out, camera_power_off_pin_oe_out, suspend_indicator_pin_out;
   logic suspend_indicator_pin_oe_out, bus_plus_line_out, bus_plus_line_oe_out;
   logic bus_minus_line_out;
   logic [3:0] alt_setting_in, reg_pkt_len_in, reg_pkt_len_out;
   logic [1:0] device_power_code_out, endpoint_count_out;
   logic [2:0] strap;
   logic [7:0] default_config_out;
   logic [13:0] video_kbps_out;
   int errors, tests_run;
   assign {eeprom_clk_core_in, eeprom_data_drive_low_in, serial_control_enable_core_in,
      camera_ctrl_data_low_in, camera_ctrl_clock_core_in, usb_plus_core_in, usb_minus_core_in,
      usb_drive_core_in} = {8{core_on}};
   uscr_ctrl i_dut (.*);
   uscr_board_model i_board (.strap_in(strap), .clk_oe_in(eeprom_clock_or_power_lsb_pin_oe_out),
      .clk_in(eeprom_clock_or_power_lsb_pin_out), .data_oe_in(eeprom_data_pin_oe_out),
      .pins_out({power_code_msb_pin_in, eeprom_clock_or_power_lsb_pin_in, eeprom_data_pin_in}));
   initial begin
      mclk_in = 1'h0;
      forever #50 mclk_in = ~mclk_in;
   end
   task chk(input logic [13:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task tick(input int n); repeat (n) @(negedge mclk_in); endtask
   task wait_rst; for (int i = 0; i < 30 && combined_reset_n_out !== 1'h1; i++) tick(1); endtask
   task cam_on(input logic v); {camera_power_on_val_in, camera_power_on_wr_in} = {v, 1'h1}; tick(1);
      camera_power_on_wr_in = 1'h0; tick(1); endtask
   task t_strap(input logic [2:0] s);
      strap = s; arst_n_in = 1'h0; tick(20);
      chk(combined_reset_n_out, 14'h0);
      arst_n_in = 1'h1; wait_rst; tick(3);
      chk({eeprom_present_out, use_default_desc_out, eeprom_clock_or_power_lsb_pin_oe_out},
         {s[2], ~s[2], s[2]});
      if (!s[2]) chk(device_power_code_out, s[1:0]);
      chk({default_config_out, endpoint_count_out}, {8'h01, 2'h3});
   endtask
   task t_rates;
      for (int a = 0; a < 16; a++) begin
         {alt_setting_in, reg_pkt_len_in} = {a[3:0], a[3:0]}; tick(2);
         chk(video_kbps_out, 14'(14'h1f40 - 14'h01f4 * a));
         chk(reg_pkt_len_out, (a < 8) ? a[3:0] : 4'h8);
      end
      chk(video_iso_out, 14'h1);
   endtask
   task t_sleep;
      core_on = 1'h1; cam_on(1'h1);
      chk({camera_power_off_pin_oe_out, video_clk_en_out}, 2'h3);
      // A camera write landing on the suspend edge must lose.
      {usb_suspend_in, camera_power_on_wr_in} = 2'h3; tick(1);
      {usb_suspend_in, camera_power_on_wr_in} = 2'h0;
      chk({suspended_out, camera_power_off_pin_oe_out, video_clk_en_out}, 3'h4);
      chk({bus_plus_line_oe_out, bus_minus_line_oe_out, suspend_indicator_pin_oe_out,
         eeprom_data_pin_oe_out, serial_control_enable_out}, 5'h0);
      chk({eeprom_clock_or_power_lsb_pin_oe_out, eeprom_clock_or_power_lsb_pin_out}, 2'h3);
      tick(4); usb_resume_in = 1'h1; tick(1); usb_resume_in = 1'h0;
      chk({suspended_out, suspend_indicator_pin_oe_out, camera_power_off_pin_oe_out,
         bus_plus_line_oe_out}, 4'h5);
   endtask
   task t_pdown;
      power_down_in = 1'h1; tick(1);
      chk({serial_control_enable_out, camera_ctrl_data_pin_oe_out, camera_ctrl_clock_pin_out,
         suspended_out, bus_plus_line_oe_out, video_clk_en_out}, 6'h02);
      chk({eeprom_data_pin_out, camera_ctrl_data_pin_out, camera_power_off_pin_out,
         suspend_indicator_pin_out, bus_plus_line_out, bus_minus_line_out}, 6'h03);
      power_down_in = 1'h0; tick(1);
      chk({serial_control_enable_out, camera_ctrl_data_pin_oe_out, camera_ctrl_clock_pin_out},
         3'h7);
   endtask
   task t_busrst;
      cam_on(1'h1);
      usb_bus_reset_in = 1'h1;
      tick(2);
      usb_bus_reset_in = 1'h0;
      chk({combined_reset_n_out, suspend_indicator_pin_oe_out, camera_power_off_pin_oe_out},
         3'h2);
      wait_rst;
      chk(combined_reset_n_out, 14'h1);
      tick(2);
      chk(eeprom_present_out, 14'h1);
   endtask
   initial begin
      {arst_n_in, usb_bus_reset_in, usb_suspend_in, usb_resume_in, power_down_in} = 5'h0;
      {core_on, camera_power_on_wr_in, camera_power_on_val_in, strap} = 6'h0;
      {alt_setting_in, reg_pkt_len_in} = 8'h0;
      for (int c = 0; c < 4; c++) t_strap(c[2:0]);
      t_strap(3'h6); t_rates; t_sleep; t_pdown; t_busrst;
      test_done;
   end
   // The sequence needs about 190 cycles; 2000 leaves ample margin for slow answers.
   initial begin
      #200000 errors++;
      test_done;
   end
endmodule
`default_nettype wire

// >>> test/uscr_board_model.sv
// Camera board model: power code straps, the EEPROM pull-up and the shared clock pin.
// Assumes that the controller's pin enables are high while it drives a pin.
`timescale 1ns/1ns
`default_nettype none
module uscr_board_model (
   input  wire [2:0] strap_in,   // EEPROM fitted, msb strap, lsb strap.
   input  wire       clk_oe_in,  // Controller drives the shared pin.
   input  wire       clk_in,     // Level that it drives.
   input  wire       data_oe_in, // Controller pulls the data pin low.
   output wire [2:0] pins_out    // Msb, shared and data pin levels.
);
   // Strap resistors are weak, so a driven level always wins over them.
   assign pins_out = {strap_in[1], clk_oe_in ? clk_in : strap_in[0],
      ~data_oe_in & strap_in[2]};
endmodule
`default_nettype wire

// >>> test/uscr_ctrl_monitor.sv
// Checker for the suspend and reset pin controller.
// Assumes a bind to the controller, whose ports carry these names.
`timescale 1ns/1ns
`default_nettype none
module uscr_ctrl_monitor (
   input wire mclk_in,   // Clock.
   input wire arst_n_in, // Reset.
   input wire usb_bus_reset_in, usb_suspend_in, usb_resume_in, power_down_in, // Requests.
   input wire combined_reset_n_out, suspended_out, suspend_indicator_pin_oe_out, // State.
   input wire bus_plus_line_oe_out, bus_minus_line_oe_out, camera_power_off_pin_oe_out, // Pins.
   input wire eeprom_clock_or_power_lsb_pin_out, eeprom_clock_or_power_lsb_pin_oe_out, // Pins.
   input wire serial_control_enable_out, camera_ctrl_data_pin_oe_out, camera_ctrl_clock_pin_out,
   input wire eeprom_data_pin_oe_out // EEPROM data pull.
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   wire run_ok = combined_reset_n_out && !usb_bus_reset_in;
   wire quiet = !(serial_control_enable_out || camera_ctrl_data_pin_oe_out
      || camera_ctrl_clock_pin_out);
   wire ee_high = eeprom_clock_or_power_lsb_pin_oe_out && eeprom_clock_or_power_lsb_pin_out;
   wire bus_on = bus_plus_line_oe_out || bus_minus_line_oe_out;
   sequence s_sleep; run_ok && usb_suspend_in && !usb_resume_in; endsequence
   sequence s_wake;
      run_ok && suspended_out && usb_resume_in && !usb_suspend_in && !power_down_in;
   endsequence
   a_enter_sleep: assert property (s_sleep |=> suspended_out) else $error("no suspend");
   a_leave_sleep: assert property (s_wake |=> !suspended_out && suspend_indicator_pin_oe_out)
      else $error("no resume");
   a_bus_float: assert property (suspended_out |-> !bus_on) else $error("bus driven");
   a_data_float: assert property (suspended_out |-> !eeprom_data_pin_oe_out)
      else $error("eeprom data driven in suspend");
   a_clock_high: assert property (suspended_out |-> ee_high) else $error("clock low");
   a_serial_quiet: assert property (suspended_out |-> quiet) else $error("serial on");
   a_pd_quiet: assert property (run_ok && power_down_in |=> quiet) else $error("serial on");
   a_cam_off: assert property ($rose(suspended_out) |-> !camera_power_off_pin_oe_out)
      else $error("camera on in suspend");
   a_reset_out: assert property (usb_bus_reset_in |=> !combined_reset_n_out [*3])
      else $error("reset output high");
endmodule
bind uscr_ctrl uscr_ctrl_monitor i_mon (.*);
`default_nettype wire
